// >>> hw/multiply_divide_unit.sv
// What this block does
// - Multiply and divide run iteratively, one shift-add (multiply) or shift-subtract (divide) step per clock.
// - All operations use one 32-bit result made of two 16-bit halves.
// - Any write to either result half sets the busy flag.
// - Reading the low half clears the busy flag; high half does not.
// - Signed and unsigned multiply; product goes to the result register.
// - Multiply sets excess flag when product needs over 16 bits.
// - Short divide takes dividend from low half; long uses both halves.
// - Division leaves quotient in low half, remainder in high half.
// - Division sets excess flag when quotient does not fit 16 bits.
// - An operation is interruptible and then sets the pending flag.
// - Interrupt return tests pending and resumes the held operation.
// - Control register and both result halves hold all state needed to restart an operation.
// - A new operation starts only with the control state cleared.
// - Status word flags can be written whole or set and cleared singly.
module multiply_divide_unit
  import mdu_pkg::*;
(
  input  wire logic        REF_CLK,
  input  wire logic        SYS_RST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        OP_INTERRUPT,
  input  wire logic        OP_RETURN,
  output logic             BUSY,
  output logic             IRQ
);

  state_s s_q;
  state_s s_d;

  logic        setup;
  logic        access;
  logic        wr;
  logic        rd;
  logic        mapped;
  logic [31:0] rdata;
  logic        start;
  op_e         cmd_op;
  logic [15:0] cmd_b;
  logic        sgn;
  logic        is_div;
  logic        is_long;
  logic [15:0] b_mag;
  logic [15:0] a_mag;
  logic [31:0] dividend;
  logic [31:0] div_mag;
  logic [16:0] mul_sum;
  logic [16:0] div_part;
  logic [16:0] div_trial;
  logic [31:0] prod;
  logic [15:0] quo_out;
  logic [15:0] rem_out;
  logic        excess;
  logic        run_sgn;
  logic        run_div;

  assign setup  = PSEL & ~PENABLE;
  assign access = PSEL & PENABLE;
  assign wr     = access & PWRITE & mapped;
  assign rd     = access & ~PWRITE & mapped;

  always_comb begin
    mapped = 1'b1;
    rdata  = 32'h0000_0000;
    case (PADDR)
      OFF_RES_LOW:  rdata = {16'h0000, s_q.lo};
      OFF_RES_HIGH: rdata = {16'h0000, s_q.hi};
      OFF_CTRL:     rdata = s_q.ctrl;
      OFF_PSW:      rdata = {16'h0000, s_q.processor_status_word};
      OFF_PSW_SET:  rdata = {16'h0000, s_q.processor_status_word};
      OFF_PSW_CLR:  rdata = {16'h0000, s_q.processor_status_word};
      OFF_OPND_A:   rdata = {16'h0000, s_q.opnd_a};
      OFF_CMD:      rdata = 32'h0000_0000;
      OFF_IRQ_STAT: rdata = {30'h0000_0000, s_q.stat};
      OFF_IRQ_MASK: rdata = {30'h0000_0000, s_q.mask};
      default:      mapped = 1'b0;
    endcase
  end

  // Command decode for a start request.
  always_comb begin
    cmd_op  = op_e'(PWDATA[CMD_OP_LSB +: 3]);
    cmd_b   = PWDATA[CMD_OPND_LSB +: 16];
    sgn     = ~cmd_op[0];
    is_div  = (cmd_op != OP_MUL) && (cmd_op != OP_UNSIGNED_MULTIPLY_INSTR);
    is_long = (cmd_op == OP_DIVL) || (cmd_op == OP_DIVLU);
    // Only encodings that name an operation are accepted.
    start   = wr && (PADDR == OFF_CMD) && (cmd_op <= OP_DIVLU) &&
              (s_q.phase != PH_RUN) && (s_q.phase != PH_FINISH) &&
              !s_q.ctrl.run && (s_q.ctrl.step == 6'h00);
    b_mag   = (sgn && cmd_b[15]) ? 16'h0000 - cmd_b : cmd_b;
    a_mag   = (sgn && s_q.opnd_a[15]) ? 16'h0000 - s_q.opnd_a : s_q.opnd_a;
    if (is_long) begin
      dividend = {s_q.hi, s_q.lo};
    end else if (sgn) begin
      dividend = {{16{s_q.lo[15]}}, s_q.lo};
    end else begin
      dividend = {16'h0000, s_q.lo};
    end
    div_mag = (sgn && dividend[31]) ? 32'h0000_0000 - dividend : dividend;
  end

  // One iteration of either algorithm on the working result halves.
  always_comb begin
    if (s_q.lo[0]) begin
      mul_sum = {1'b0, s_q.hi} + {1'b0, s_q.ctrl.operand};
    end else begin
      mul_sum = {1'b0, s_q.hi};
    end
    div_part  = {s_q.hi, s_q.lo[15]};
    div_trial = div_part - {1'b0, s_q.ctrl.operand};
  end

  // Result formatting at the end of an operation.
  always_comb begin
    run_sgn = ~s_q.ctrl.op[0];
    run_div = (s_q.ctrl.op != OP_MUL) && (s_q.ctrl.op != OP_UNSIGNED_MULTIPLY_INSTR);
    prod    = s_q.ctrl.neg_q ? 32'h0000_0000 - {s_q.hi, s_q.lo}
                             : {s_q.hi, s_q.lo};
    quo_out = s_q.ctrl.neg_q ? 16'h0000 - s_q.lo : s_q.lo;
    rem_out = s_q.ctrl.neg_r ? 16'h0000 - s_q.hi : s_q.hi;
    if (!run_div) begin
      if (run_sgn) begin
        excess = prod[31:16] != {16{prod[15]}};
      end else begin
        excess = prod[31:16] != 16'h0000;
      end
    end else if (run_sgn) begin
      excess = s_q.ctrl.neg_q ? (s_q.lo > QUO_NEG_MAX)
                              : (s_q.lo > QUO_POS_MAX);
    end else begin
      excess = 1'b0;
    end
  end

  always_comb begin
    s_d = s_q;

    if (setup) begin
      s_d.prdata = rdata;
      s_d.slverr = ~mapped;
    end

    // Clears from software come first so that hardware sets win.
    if (rd && (PADDR == OFF_RES_LOW)) begin
      s_d.ctrl.busy = 1'b0;
    end
    if (rd && (PADDR == OFF_IRQ_STAT)) begin
      s_d.stat = '0;
    end

    if (wr) begin
      case (PADDR)
        OFF_RES_LOW: begin
          s_d.lo        = PWDATA[15:0];
          s_d.ctrl.busy = 1'b1;
        end
        OFF_RES_HIGH: begin
          s_d.hi        = PWDATA[15:0];
          s_d.ctrl.busy = 1'b1;
        end
        OFF_CTRL:     s_d.ctrl   = PWDATA;
        OFF_PSW:      s_d.processor_status_word    = PWDATA[15:0];
        OFF_PSW_SET:  s_d.processor_status_word    = s_q.processor_status_word | PWDATA[15:0];
        OFF_PSW_CLR:  s_d.processor_status_word    = s_q.processor_status_word & ~PWDATA[15:0];
        OFF_OPND_A:   s_d.opnd_a = PWDATA[15:0];
        OFF_IRQ_MASK: s_d.mask   = PWDATA[1:0];
        default:      s_d.processor_status_word    = s_d.processor_status_word;
      endcase
      s_d.processor_status_word.rsvd = 14'h0000;
    end

    case (s_q.phase)
      PH_IDLE, PH_HELD: begin
        if (start) begin
          s_d.ctrl.op    = cmd_op;
          s_d.ctrl.step  = 6'h00;
          s_d.ctrl.neg_r = 1'b0;
          s_d.ctrl.busy  = 1'b1;
          if (!is_div) begin
            s_d.lo            = a_mag;
            s_d.hi            = 16'h0000;
            s_d.ctrl.operand  = b_mag;
            s_d.ctrl.neg_q    = sgn & (s_q.opnd_a[15] ^ cmd_b[15]);
            s_d.ctrl.run      = 1'b1;
            s_d.phase         = PH_RUN;
          end else if (div_mag[31:16] >= b_mag) begin
            // The quotient cannot fit 16 bits, or the divisor is zero.
            s_d.processor_status_word.excess    = 1'b1;
            s_d.stat.done     = 1'b1;
            s_d.stat.ovf      = 1'b1;
            s_d.phase         = PH_IDLE;
          end else begin
            s_d.hi            = div_mag[31:16];
            s_d.lo            = div_mag[15:0];
            s_d.ctrl.operand  = b_mag;
            s_d.ctrl.neg_q    = sgn & (dividend[31] ^ cmd_b[15]);
            s_d.ctrl.neg_r    = sgn & dividend[31];
            s_d.ctrl.run      = 1'b1;
            s_d.phase         = PH_RUN;
          end
        end else if (OP_RETURN && s_q.processor_status_word.pending) begin
          // The routine has put back the saved control state.
          s_d.processor_status_word.pending = 1'b0;
          if (s_q.ctrl.run) begin
            s_d.phase = PH_RUN;
          end else begin
            s_d.phase = PH_IDLE;
          end
        end
      end
      PH_RUN: begin
        if (OP_INTERRUPT) begin
          s_d.phase       = PH_HELD;
          s_d.processor_status_word.pending = 1'b1;
        end else if (!s_q.ctrl.run) begin
          // Software cleared the control state under a running operation.
          s_d.phase = PH_IDLE;
        end else begin
          if (!run_div) begin
            s_d.hi = mul_sum[16:1];
            s_d.lo = {mul_sum[0], s_q.lo[15:1]};
          end else if (div_part >= {1'b0, s_q.ctrl.operand}) begin
            s_d.hi = div_trial[15:0];
            s_d.lo = {s_q.lo[14:0], 1'b1};
          end else begin
            s_d.hi = div_part[15:0];
            s_d.lo = {s_q.lo[14:0], 1'b0};
          end
          s_d.ctrl.step = s_q.ctrl.step + 6'h01;
          if (s_q.ctrl.step == STEP_LAST) begin
            s_d.phase = PH_FINISH;
          end
        end
      end
      PH_FINISH: begin
        if (!run_div) begin
          s_d.hi = prod[31:16];
          s_d.lo = prod[15:0];
        end else begin
          s_d.lo = quo_out;
          s_d.hi = rem_out;
        end
        s_d.processor_status_word.excess = excess;
        s_d.ctrl.busy  = 1'b1;
        s_d.ctrl.run   = 1'b0;
        s_d.ctrl.step  = 6'h00;
        s_d.ctrl.neg_q = 1'b0;
        s_d.ctrl.neg_r = 1'b0;
        s_d.stat.done  = 1'b1;
        if (excess) begin
          s_d.stat.ovf = 1'b1;
        end
        s_d.phase = PH_IDLE;
      end
      default: s_d.phase = PH_IDLE;
    endcase

    s_d.ctrl.rsvd = 3'h0;
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      s_q <= STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign PRDATA  = s_q.prdata;
  assign PREADY  = 1'b1;
  assign PSLVERR = access & s_q.slverr;
  assign BUSY    = (s_q.phase == PH_RUN) || (s_q.phase == PH_FINISH);
  assign IRQ     = |(s_q.stat & s_q.mask);

endmodule

// >>> hw/mdu_pkg.sv
package mdu_pkg;

  // Byte offsets of the registers on the APB port.
  localparam logic [7:0] OFF_RES_LOW   = 8'h00;
  localparam logic [7:0] OFF_RES_HIGH  = 8'h04;
  localparam logic [7:0] OFF_CTRL      = 8'h08;
  localparam logic [7:0] OFF_PSW       = 8'h0C;
  localparam logic [7:0] OFF_PSW_SET   = 8'h10;
  localparam logic [7:0] OFF_PSW_CLR   = 8'h14;
  localparam logic [7:0] OFF_OPND_A    = 8'h18;
  localparam logic [7:0] OFF_CMD       = 8'h1C;
  localparam logic [7:0] OFF_IRQ_STAT  = 8'h20;
  localparam logic [7:0] OFF_IRQ_MASK  = 8'h24;

  // Field positions.
  localparam int PSW_EXCESS_BIT  = 0;
  localparam int PSW_PENDING_BIT = 1;
  localparam int IRQ_DONE_BIT    = 0;
  localparam int IRQ_OVF_BIT     = 1;
  localparam int CTRL_BUSY_BIT   = 0;
  localparam int CMD_OP_LSB      = 0;
  localparam int CMD_OPND_LSB    = 16;

  // Iteration count of one operation and its last step index.
  localparam logic [5:0] STEP_LAST = 6'h0F;

  // Signed quotient limits.
  localparam logic [15:0] QUO_POS_MAX = 16'h7FFF;
  localparam logic [15:0] QUO_NEG_MAX = 16'h8000;

  typedef enum logic [2:0] {
    OP_MUL   = 3'b000,
    OP_UNSIGNED_MULTIPLY_INSTR  = 3'b001,
    OP_DIV   = 3'b010,
    OP_DIVU  = 3'b011,
    OP_DIVL  = 3'b100,
    OP_DIVLU = 3'b101
  } op_e;

  typedef enum logic [1:0] {
    PH_IDLE   = 2'b00,
    PH_RUN    = 2'b01,
    PH_FINISH = 2'b10,
    PH_HELD   = 2'b11
  } phase_e;

  typedef struct packed {
    logic [15:0] operand;
    logic [5:0]  step;
    op_e         op;
    logic        neg_q;
    logic        neg_r;
    logic        run;
    logic [2:0]  rsvd;
    logic        busy;
  } ctrl_s;

  typedef struct packed {
    logic [13:0] rsvd;
    logic        pending;
    logic        excess;
  } psw_s;

  typedef struct packed {
    logic ovf;
    logic done;
  } irq_s;

  typedef struct packed {
    phase_e      phase;
    ctrl_s       ctrl;
    psw_s        processor_status_word;
    logic [15:0] lo;
    logic [15:0] hi;
    logic [15:0] opnd_a;
    irq_s        stat;
    irq_s        mask;
    logic [31:0] prdata;
    logic        slverr;
  } state_s;

  localparam state_s STATE_RST = '0;

endpackage

// >>> verification/cpu_seq_model.sv
module cpu_seq_model (
  input  wire logic clk,
  input  wire logic do_int,
  input  wire logic do_ret,
  output logic      op_int,
  output logic      op_ret
);
  timeunit 1ns;
  timeprecision 1ps;
  // Acknowledge and return reach the unit as one-cycle pulses.
  // Both pulses reach the unit one clock after the testbench drives them.
  always @(posedge clk) begin
    op_int <= do_int;
    op_ret <= do_ret;
  end
endmodule

// >>> verification/multiply_divide_unit_properties.sv
module multiply_divide_unit_properties
  import mdu_pkg::*;
(
  input wire logic        REF_CLK,
  input wire logic        SYS_RST,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        OP_INTERRUPT,
  input wire logic        OP_RETURN,
  input wire logic        BUSY
);
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (SYS_RST);
  logic acc;
  logic cmd_wr;
  assign acc = PSEL && PENABLE;
  assign cmd_wr = acc && PWRITE && PADDR == OFF_CMD;
  property p_go;
    $rose(BUSY) |-> $past(cmd_wr) || $past(OP_RETURN) || $past(OP_RETURN, 2);
  endproperty
  a_go: assert property (p_go) else $error("busy without start");
  property p_multi; $rose(BUSY) && !OP_INTERRUPT |=> BUSY; endproperty
  a_multi: assert property (p_multi) else $error("one-cycle op");
  property p_stop; BUSY && OP_INTERRUPT |=> !BUSY; endproperty
  a_stop: assert property (p_stop) else $error("op not held");
  property p_erracc; PSLVERR |-> acc; endproperty
  a_erracc: assert property (p_erracc) else $error("stray error");
  property p_unmap; acc && PADDR > OFF_IRQ_MASK |-> PSLVERR; endproperty
  a_unmap: assert property (p_unmap) else $error("no error");
  property p_map;
    acc && PADDR <= OFF_IRQ_MASK && PADDR[1:0] == 2'b00 |-> PREADY && !PSLVERR;
  endproperty
  a_map: assert property (p_map) else $error("mapped refused");
  property p_cmdrd; acc && !PWRITE && PADDR == OFF_CMD |-> PRDATA == '0; endproperty
  a_cmdrd: assert property (p_cmdrd) else $error("command read");
  property p_half;
    acc && !PWRITE && PADDR <= OFF_RES_HIGH && PADDR[1:0] == 2'b00
      |-> PRDATA[31:16] == 16'h0;
  endproperty
  a_half: assert property (p_half) else $error("half too wide");
endmodule

bind multiply_divide_unit multiply_divide_unit_properties u_props (
  .REF_CLK, .SYS_RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PRDATA, .PREADY,
  .PSLVERR, .OP_INTERRUPT, .OP_RETURN, .BUSY);

// >>> verification/multiply_divide_unit_test.sv
module multiply_divide_unit_test;
  import mdu_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, psel, pen, pwr, pready, pslverr, busy, irq;
  logic        di, dr, oi, orr, er;
  logic [7:0]  paddr;
  logic [15:0] a, b;
  logic [31:0] pwdata, prdata, rd, c, h, l;
  logic [32:0] e;
  int          failures, checks;

  multiply_divide_unit DUT (.REF_CLK(clk), .SYS_RST(rst), .PSEL(psel),
    .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .OP_INTERRUPT(oi), .OP_RETURN(orr), .BUSY(busy), .IRQ(irq));
  cpu_seq_model partner (.clk(clk), .do_int(di), .do_ret(dr),
    .op_int(oi), .op_ret(orr));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  function automatic logic [32:0] mul_exp(logic sg, logic [15:0] x, y);
    logic [31:0] p;
    p = sg ? {{16{x[15]}}, x} * {{16{y[15]}}, y} : {16'h0, x} * {16'h0, y};
    return {sg ? p[31:16] != {16{p[15]}} : p[31:16] != 16'h0, p};
  endfunction

  function automatic logic [31:0] div_exp(int n, int d);
    return {16'(n % d), 16'(n / d)};
  endfunction

  task automatic close_out;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(string n, logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic apb(logic w, logic [7:0] ad, logic [31:0] d);
    @(posedge clk);
    {psel, pwr, paddr, pwdata} <= {1'b1, w, ad, d};
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, pen} <= 2'b00;
  endtask

  task automatic rc(string n, logic [7:0] ad, logic [31:0] m, exp);
    apb(1'b0, ad, 32'h0);
    chk(n, rd & m, exp);
  endtask

  task automatic settle;
    repeat (2) @(posedge clk);
    for (int n = 0; n < 40 && busy !== 1'b0; n++) @(posedge clk);
    chk("busy", {31'h0, busy}, 32'h0);
  endtask

  task automatic div_case(op_e op, logic [31:0] n, logic [15:0] d,
                          logic [32:0] x);
    apb(1'b1, OFF_RES_HIGH, {16'h0, n[31:16]});
    apb(1'b1, OFF_RES_LOW, {16'h0, n[15:0]});
    apb(1'b1, OFF_CMD, {d, 13'h0, op});
    settle();
    rc("rem", OFF_RES_HIGH, '1, {16'h0, x[31:16]});
    rc("quo", OFF_RES_LOW, '1, {16'h0, x[15:0]});
    rc("ovf", OFF_PSW, 32'h1, {31'h0, x[32]});
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    close_out();
  end

  initial begin
    {psel, pen, pwr, di, dr, paddr, pwdata, rst} = 46'h1;
    void'($urandom(32'h74F6));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rc("ctrl", OFF_CTRL, '1, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk("err", {31'h0, er}, 32'h1);
    apb(1'b1, OFF_PSW, 32'h3);
    apb(1'b1, OFF_PSW_CLR, 32'h1);
    rc("psw", OFF_PSW_SET, '1, 32'h2);
    apb(1'b1, OFF_PSW, 32'h0);
    $display("register test done");
    for (int i = 0; i < 8; i++) begin
      a = (i < 2) ? {i[0], 15'h0} - 16'(i) : 16'($urandom);
      b = (i < 2) ? a : 16'($urandom);
      e = mul_exp(~i[0], a, b);
      apb(1'b1, OFF_IRQ_MASK, {30'h0, 1'b1, i[1]});
      apb(1'b1, OFF_OPND_A, {16'h0, a});
      apb(1'b1, OFF_CMD, {b, 13'h0, i[0] ? OP_UNSIGNED_MULTIPLY_INSTR : OP_MUL});
      settle();
      chk("irq", {31'h0, irq}, {31'h0, i[1] | e[32]});
      rc("hi", OFF_RES_HIGH, '1, {16'h0, e[31:16]});
      rc("flag", OFF_CTRL, 32'h1, 32'h1);
      rc("lo", OFF_RES_LOW, '1, {16'h0, e[15:0]});
      rc("flag", OFF_CTRL, 32'h1, 32'h0);
      rc("exc", OFF_PSW, 32'h1, {31'h0, e[32]});
      rc("stat", OFF_IRQ_STAT, 32'h3, {30'h0, e[32], 1'b1});
      @(negedge clk);
      chk("irq", {31'h0, irq}, 32'h0);
    end
    $display("multiply test done");
    a = 16'($urandom);
    b = 16'($urandom_range(16'hFFFF, 1));
    div_case(OP_DIVU, {16'hBEEF, a}, b, {1'b0, div_exp(int'(a), int'(b))});
    div_case(OP_DIVL, 32'hFFFE7960, 16'h0007, {1'b0, div_exp(-100000, 7)});
    div_case(OP_DIV, 32'h8000, 16'hFFFF, {1'b1, div_exp(-32768, -1)});
    div_case(OP_DIVLU, 32'h00050000, 16'h0003, 33'h100050000);
    $display("divide test done");
    apb(1'b1, OFF_OPND_A, 32'h1234);
    apb(1'b1, OFF_CMD, {16'h0011, 13'h0, OP_UNSIGNED_MULTIPLY_INSTR});
    repeat (4) @(posedge clk);
    di <= 1'b1;
    @(posedge clk);
    di <= 1'b0;
    repeat (3) @(posedge clk);
    chk("held", {31'h0, busy}, 32'h0);
    rc("pend", OFF_PSW, 32'h2, 32'h2);
    apb(1'b1, OFF_CMD, {16'h0005, 13'h0, OP_MUL});
    repeat (3) @(posedge clk);
    chk("refuse", {31'h0, busy}, 32'h0);
    apb(1'b0, OFF_CTRL, 32'h0);
    c = rd;
    chk("run", {31'h0, c[4]}, 32'h1);
    apb(1'b0, OFF_RES_HIGH, 32'h0);
    h = rd;
    apb(1'b0, OFF_RES_LOW, 32'h0);
    l = rd;
    apb(1'b1, OFF_CTRL, 32'h0);
    apb(1'b1, OFF_OPND_A, 32'h3);
    apb(1'b1, OFF_CMD, {16'h0005, 13'h0, OP_MUL});
    settle();
    rc("nest", OFF_RES_LOW, '1, 32'hF);
    apb(1'b1, OFF_OPND_A, 32'h1234);
    apb(1'b1, OFF_RES_LOW, l);
    apb(1'b1, OFF_RES_HIGH, h);
    apb(1'b1, OFF_CTRL, c);
    dr <= 1'b1;
    @(posedge clk);
    dr <= 1'b0;
    repeat (3) @(posedge clk);
    settle();
    rc("hi", OFF_RES_HIGH, '1, 32'h1);
    rc("lo", OFF_RES_LOW, '1, 32'h3574);
    rc("pend", OFF_PSW, 32'h2, 32'h0);
    $display("interrupt test done");
    close_out();
  end
endmodule
